// *** design/adcc_conversion_control.v ***
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"

module adcc_conversion_control (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Trigger sources and interrupt service
    input wire [7:0] trigger_sources,
    input wire irq_ack,
    output wire irq,
    // Analog front end
    input wire comparator_in,
    output wire analog_enable,
    output reg [5:0] channel_select_out,
    output reg [2:0] reference_select_out,
    output reg gain_select_out,
    output wire amp_bypass,
    output wire temp_sensor_en,
    output wire sample_hold,
    output reg [9:0] dac_code
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Last count of the prescaler: divide by 2 for codes 0 and 1, else 2^ps
    function [6:0] adcc_div_last;
        input [2:0] ps;
        begin
            if (ps < 3'd2) begin
                adcc_div_last = 7'd1;
            end else begin
                adcc_div_last = (7'd1 << (ps - 3'd1)) + (7'd1 << (ps - 3'd1)) - 7'd1;
            end
        end
    endfunction

    // Single-ended codes are plain pins or the temperature sensor
    function adcc_single_ended;
        input [5:0] ch;
        begin
            adcc_single_ended = (ch <= `ADCC_CH_LAST_SINGLE) || (ch == `ADCC_CH_TEMP_SENSOR);
        end
    endfunction

    // ------------------------------------------------------------------
    // Software-visible state
    // ------------------------------------------------------------------
    reg [5:0] channel_select_reg;
    reg [2:0] reference_select_reg;
    reg left_adjust_reg;
    reg conv_enable_reg;
    reg auto_trigger_enable_reg;
    reg conversion_complete_flag_reg;
    reg irq_enable_reg;
    reg [2:0] prescale_reg;
    reg [2:0] trigger_select_reg;
    reg gain_select_reg;
    reg [9:0] result_reg;
    reg result_lock_reg;

    // Conversion engine state
    reg start_pending_reg;
    reg busy_reg;
    reg first_conv_reg;
    reg [4:0] cycle_reg;
    reg [3:0] sar_bit_reg;
    reg [6:0] prescale_cnt_reg;
    reg trig_prev_reg;
    reg comp_meta_reg;
    reg comp_sync_reg;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire access = psel && penable;
    wire wr_en = access && pwrite;
    wire rd_en = access && !pwrite;
    wire hit_mux = (paddr == `ADCC_OFS_MUX_SELECT);
    wire hit_ca = (paddr == `ADCC_OFS_CONTROL_A);
    wire hit_cb = (paddr == `ADCC_OFS_CONTROL_B);
    wire hit_lo = (paddr == `ADCC_OFS_RESULT_LOW);
    wire hit_hi = (paddr == `ADCC_OFS_RESULT_HIGH);
    wire mapped = hit_mux || hit_ca || hit_cb || hit_lo || hit_hi;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    wire wr_ca = wr_en && hit_ca;
    wire start_write = wr_ca && pwdata[`ADCC_CA_START];

    // ------------------------------------------------------------------
    // Converter clock and timing
    // ------------------------------------------------------------------
    wire [4:0] conv_len = first_conv_reg ? `ADCC_CYC_FIRST : `ADCC_CYC_NORMAL;
    wire last_cycle = busy_reg && (cycle_reg == conv_len - 5'd1);
    wire adc_tick = conv_enable_reg && (prescale_cnt_reg == adcc_div_last(prescale_reg));
    wire complete = adc_tick && last_cycle;

    // Trigger source; code 0 restarts on each own completion, whatever the flag holds
    wire trig_level = trigger_sources[trigger_select_reg];
    wire trig_edge = trig_level && !trig_prev_reg;
    wire self_trig = (trigger_select_reg == `ADCC_TRIG_SELF);
    wire auto_start = conv_enable_reg && auto_trigger_enable_reg && !self_trig
                      && trig_edge && !busy_reg && !start_pending_reg;
    wire free_restart = complete && auto_trigger_enable_reg && self_trig;

    // Trigger edge resets prescaler so the start lands at a fixed delay
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_cnt_reg <= 7'd0;
        end else if (!conv_enable_reg || auto_start) begin
            prescale_cnt_reg <= 7'd0;
        end else if (adc_tick) begin
            prescale_cnt_reg <= 7'd0;
        end else begin
            prescale_cnt_reg <= prescale_cnt_reg + 7'd1;
        end
    end

    // Previous trigger level, for edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= self_trig ? 1'b0 : trig_level;
        end
    end

    // Comparator crosses from the analog side through two flops
    // Limitation: a trial needs three pclk per tick to be seen in time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= comparator_in;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------------
    // Pending start waits for the next converter tick; a start request
    // while busy is already covered by the running conversion.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pending_reg <= 1'b0;
            busy_reg <= 1'b0;
            cycle_reg <= 5'd0;
            first_conv_reg <= 1'b1;
        end else if (!conv_enable_reg) begin
            // Disabling aborts and rearms the long first conversion
            start_pending_reg <= 1'b0;
            busy_reg <= 1'b0;
            cycle_reg <= 5'd0;
            first_conv_reg <= 1'b1;
        end else begin
            if ((start_write || auto_start) && !busy_reg) begin
                start_pending_reg <= 1'b1;
            end else if (adc_tick && start_pending_reg) begin
                start_pending_reg <= 1'b0;
            end
            if (adc_tick) begin
                if (complete) begin
                    first_conv_reg <= 1'b0;
                    cycle_reg <= 5'd0;
                    busy_reg <= free_restart;
                end else if (busy_reg) begin
                    cycle_reg <= cycle_reg + 5'd1;
                end else if (start_pending_reg) begin
                    busy_reg <= 1'b1;
                    cycle_reg <= 5'd0;
                end
            end
        end
    end

    // Successive approximation: eleven ticks end the conversion, the first
    // sets the top trial bit and each later one settles a bit.
    wire [4:0] sar_first = conv_len - `ADCC_SAR_STEPS;
    wire sar_active = busy_reg && (cycle_reg >= sar_first);
    assign sample_hold = busy_reg && (cycle_reg < sar_first);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= 10'h000;
            sar_bit_reg <= 4'd9;
        end else if (adc_tick && sar_active) begin
            if (cycle_reg == sar_first) begin
                dac_code <= 10'h200;
                sar_bit_reg <= 4'd9;
            end else begin
                // Comparator low means input below trial: drop the bit
                if (!comp_sync_reg) begin
                    dac_code[sar_bit_reg] <= 1'b0;
                end
                if (sar_bit_reg != 4'd0) begin
                    dac_code[sar_bit_reg - 4'd1] <= 1'b1;
                    sar_bit_reg <= sar_bit_reg - 4'd1;
                end
            end
        end
    end

    // Final code includes the last settled bit
    wire [9:0] final_code = comp_sync_reg ? dac_code : (dac_code & 10'h3fe);

    // ------------------------------------------------------------------
    // Result registers and read lock
    // ------------------------------------------------------------------
    wire rd_lo = rd_en && hit_lo;
    wire rd_hi = rd_en && hit_hi;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= `ADCC_RST_RESULT;
        end else if (complete && !result_lock_reg) begin
            result_reg <= final_code;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_lock_reg <= 1'b0;
        end else if (rd_hi) begin
            result_lock_reg <= 1'b0;
        end else if (rd_lo) begin
            result_lock_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_select_reg <= `ADCC_RST_CH;
            reference_select_reg <= `ADCC_RST_REF;
            left_adjust_reg <= 1'b0;
            conv_enable_reg <= 1'b0;
            auto_trigger_enable_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            prescale_reg <= `ADCC_RST_PS;
            trigger_select_reg <= `ADCC_RST_TRIG;
            gain_select_reg <= 1'b0;
        end else if (wr_en) begin
            if (hit_mux) begin
                channel_select_reg <= pwdata[`ADCC_MUX_CH_MSB:`ADCC_MUX_CH_LSB];
                reference_select_reg <= pwdata[`ADCC_MUX_REF_MSB:`ADCC_MUX_REF_LSB];
                left_adjust_reg <= pwdata[`ADCC_MUX_LEFT_ADJUST];
            end
            if (hit_ca) begin
                conv_enable_reg <= pwdata[`ADCC_CA_ENABLE];
                auto_trigger_enable_reg <= pwdata[`ADCC_CA_AUTO_TRIG];
                irq_enable_reg <= pwdata[`ADCC_CA_IRQ_ENABLE];
                prescale_reg <= pwdata[`ADCC_CA_PS_MSB:`ADCC_CA_PS_LSB];
            end
            if (hit_cb) begin
                trigger_select_reg <= pwdata[`ADCC_CB_TRIG_MSB:`ADCC_CB_TRIG_LSB];
                gain_select_reg <= pwdata[`ADCC_CB_GAIN_SELECT];
            end
        end
    end

    // Completion flag: a completion in the same cycle as a clear wins
    wire flag_clear = (wr_ca && pwdata[`ADCC_CA_FLAG]) || irq_ack;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_complete_flag_reg <= 1'b0;
        end else if (complete) begin
            conversion_complete_flag_reg <= 1'b1;
        end else if (flag_clear) begin
            conversion_complete_flag_reg <= 1'b0;
        end
    end

    assign irq = conversion_complete_flag_reg && irq_enable_reg;

    // ------------------------------------------------------------------
    // Buffered selections toward the analog side
    // ------------------------------------------------------------------
    // Held through sampling so the input settles; reopened in the final
    // cycle so the next conversion uses the new setting.
    wire sel_update = conv_enable_reg && (!busy_reg || last_cycle) && !start_pending_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_select_out <= `ADCC_RST_CH;
            reference_select_out <= `ADCC_RST_REF;
            gain_select_out <= 1'b0;
        end else if (sel_update) begin
            channel_select_out <= channel_select_reg;
            reference_select_out <= reference_select_reg;
            gain_select_out <= gain_select_reg;
        end
    end

    assign analog_enable = conv_enable_reg;
    assign amp_bypass = adcc_single_ended(channel_select_out);
    assign temp_sensor_en = conv_enable_reg
                            && (channel_select_out == `ADCC_CH_TEMP_SENSOR);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Alignment is applied on read, so a change of left_adjust shows at once
    wire [7:0] res_high = left_adjust_reg ? result_reg[9:2] : {6'h00, result_reg[9:8]};
    wire [7:0] res_low = left_adjust_reg ? {result_reg[1:0], 6'h00} : result_reg[7:0];

    always @* begin
        prdata = 32'h0000_0000;
        if (hit_mux) begin
            prdata[`ADCC_MUX_CH_MSB:`ADCC_MUX_CH_LSB] = channel_select_reg;
            prdata[`ADCC_MUX_LEFT_ADJUST] = left_adjust_reg;
            prdata[`ADCC_MUX_REF_MSB:`ADCC_MUX_REF_LSB] = reference_select_reg;
        end else if (hit_ca) begin
            prdata[`ADCC_CA_ENABLE] = conv_enable_reg;
            prdata[`ADCC_CA_START] = start_pending_reg || busy_reg;
            prdata[`ADCC_CA_AUTO_TRIG] = auto_trigger_enable_reg;
            prdata[`ADCC_CA_FLAG] = conversion_complete_flag_reg;
            prdata[`ADCC_CA_IRQ_ENABLE] = irq_enable_reg;
            prdata[`ADCC_CA_PS_MSB:`ADCC_CA_PS_LSB] = prescale_reg;
        end else if (hit_cb) begin
            prdata[`ADCC_CB_TRIG_MSB:`ADCC_CB_TRIG_LSB] = trigger_select_reg;
            prdata[`ADCC_CB_GAIN_SELECT] = gain_select_reg;
        end else if (hit_lo) begin
            prdata[7:0] = res_low;
        end else if (hit_hi) begin
            prdata[7:0] = res_high;
        end
    end

endmodule // adcc_conversion_control
`default_nettype wire

// *** design/adcc_consts.vh ***
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADCC_OFS_MUX_SELECT 8'h00
`define ADCC_OFS_CONTROL_A 8'h04
`define ADCC_OFS_CONTROL_B 8'h08
`define ADCC_OFS_RESULT_LOW 8'h0c
`define ADCC_OFS_RESULT_HIGH 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
// mux_select_register
`define ADCC_MUX_CH_LSB 0
`define ADCC_MUX_CH_MSB 5
`define ADCC_MUX_LEFT_ADJUST 7
`define ADCC_MUX_REF_LSB 8
`define ADCC_MUX_REF_MSB 10
// conv_control_a
`define ADCC_CA_PS_LSB 0
`define ADCC_CA_PS_MSB 2
`define ADCC_CA_IRQ_ENABLE 3
`define ADCC_CA_FLAG 4
`define ADCC_CA_AUTO_TRIG 5
`define ADCC_CA_START 6
`define ADCC_CA_ENABLE 7
// conv_control_b
`define ADCC_CB_TRIG_LSB 0
`define ADCC_CB_TRIG_MSB 2
`define ADCC_CB_GAIN_SELECT 7

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define ADCC_RST_CH 6'h00
`define ADCC_RST_REF 3'h0
`define ADCC_RST_PS 3'h0
`define ADCC_RST_TRIG 3'h0
`define ADCC_RST_RESULT 10'h000
`define ADCC_TRIG_SELF 3'h0
`define ADCC_CH_LAST_SINGLE 6'h0a
`define ADCC_CH_TEMP_SENSOR 6'h3f

// ----------------------------------------------------------------------
// Timing in converter clock cycles
// ----------------------------------------------------------------------
`define ADCC_CYC_NORMAL 5'd13
`define ADCC_CYC_FIRST 5'd25
`define ADCC_SAR_STEPS 5'd11

`endif

// *** verif/adcc_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Ideal analog input and comparator
// ------------------------------------------
module adcc_analog_model (
    // Input level and trial code
    input wire logic [9:0] level,
    input wire logic [9:0] dac_code,
    // Comparator answer
    output logic comparator_in
);
    // Ideal compare, so a clean search lands exactly on the level
    assign comparator_in = (level >= dac_code);
endmodule // adcc_analog_model
`default_nettype wire

// *** verif/adcc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Port checker
// ------------------------------------------
module adcc_checker (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    // Converter side
    input wire logic irq,
    input wire logic analog_enable,
    input wire logic [5:0] channel_select_out,
    input wire logic [2:0] reference_select_out,
    input wire logic amp_bypass,
    input wire logic temp_sensor_en,
    input wire logic sample_hold,
    input wire logic [9:0] dac_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Read access phase of the control word
    wire rd_ca = psel && penable && !pwrite && paddr == 8'h04;

    // Selections frozen while sampling
    a_hold_locks_sel: assert property (sample_hold ##1 sample_hold |->
        $stable(channel_select_out) && $stable(reference_select_out))
        else $error("selection moved while sampling");
    a_off_no_hold: assert property (!analog_enable ##1 !analog_enable |-> !sample_hold)
        else $error("sampling while disabled");
    a_irq_has_flag: assert property (rd_ca && irq |-> prdata[4])
        else $error("request without completion flag");
    a_busy_reads_start: assert property (rd_ca && sample_hold |-> prdata[6])
        else $error("start bit low during conversion");
    a_enable_reads: assert property (rd_ca |-> prdata[7] == analog_enable)
        else $error("enable readback differs from analog enable");
    a_temp_channel: assert property (temp_sensor_en ==
        (analog_enable && channel_select_out == 6'h3f))
        else $error("temperature sensor select wrong");
    a_single_bypass: assert property (amp_bypass ==
        (channel_select_out <= 6'h0a || channel_select_out == 6'h3f))
        else $error("gain bypass wrong for channel");
    // Midscale trial lands one converter tick after sampling ends
    a_sar_first_trial: assert property ($fell(sample_hold) && analog_enable |->
        ##[1:128] dac_code == 10'h200)
        else $error("search does not begin at midscale");
endmodule // adcc_checker

bind adcc_conversion_control adcc_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .irq, .analog_enable, .channel_select_out, .reference_select_out,
    .amp_bypass, .temp_sensor_en, .sample_hold, .dac_code);
`default_nettype wire

// *** verif/adcc_conversion_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"
// ------------------------------------------
// Self-checking bench
// ------------------------------------------
module adcc_conversion_control_bench;
    logic pclk, presetn, psel, penable, pwrite, irq_ack, e;
    logic pready, pslverr, irq, comparator_in, analog_enable, gain_select_out;
    logic amp_bypass, temp_sensor_en, sample_hold;
    logic [7:0] paddr, trigger_sources;
    logic [31:0] pwdata, prdata, q;
    logic [5:0] channel_select_out;
    logic [2:0] reference_select_out;
    logic [9:0] dac_code, level;
    int num_errors, comparisons, cyc, n;

    // Design and its ideal analog side
    adcc_conversion_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .trigger_sources, .irq_ack, .irq, .comparator_in,
        .analog_enable, .channel_select_out, .reference_select_out, .gain_select_out,
        .amp_bypass, .temp_sensor_en, .sample_hold, .dac_code);
    adcc_analog_model analog (.level, .dac_code, .comparator_in);

    // Clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Hang guard; the full run needs well under this
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            $display("BAD %0t run hung", $time);
            tally_and_finish();
        end
    end

    // One transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wca(input logic [31:0] d);
        apb(1'b1, `ADCC_OFS_CONTROL_A, d);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Poll until the start bit drops; polling never touches result bytes
    task automatic wait_idle;
        do
            rd(`ADCC_OFS_CONTROL_A);
        while (q[6] !== 1'b0);
    endtask
    task automatic convert(input logic [9:0] v, input logic [31:0] ctl);
        int t0;
        level <= v;
        t0 = cyc;
        wca(ctl | 32'h40);
        wait_idle();
        n = cyc - t0;
    endtask

    // Reset values, start while off, unmapped access
    task automatic t_reset;
        rd(`ADCC_OFS_MUX_SELECT);
        chk(q, 32'h0);
        rd(`ADCC_OFS_CONTROL_B);
        chk(q, 32'h0);
        wca(32'h40);
        rd(`ADCC_OFS_CONTROL_A);
        chk(q, 32'h0);
        rd(8'h14);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask

    // First and normal conversion lengths, both alignments
    task automatic t_conv;
        apb(1'b1, `ADCC_OFS_MUX_SELECT, 32'h23f);
        apb(1'b1, `ADCC_OFS_CONTROL_B, 32'h80);
        chk({29'h0, reference_select_out}, 32'h0);
        wca(32'h83);
        rd(`ADCC_OFS_CONTROL_A);
        chk({31'h0, temp_sensor_en & amp_bypass}, 32'h1);
        chk({28'h0, gain_select_out, reference_select_out}, 32'ha);
        apb(1'b1, `ADCC_OFS_MUX_SELECT, 32'h03);
        convert(10'h2b5, 32'h83);
        chk({31'h0, n >= 200 && n <= 220}, 32'h1);
        chk(q & 32'h10, 32'h10);
        rd(`ADCC_OFS_RESULT_LOW);
        chk(q, 32'hb5);
        rd(`ADCC_OFS_RESULT_HIGH);
        chk(q, 32'h2);
        convert(10'h0c3, 32'h93);
        chk({31'h0, n >= 104 && n <= 124}, 32'h1);
        apb(1'b1, `ADCC_OFS_MUX_SELECT, 32'h83);
        convert(10'h1c6, 32'h93);
        rd(`ADCC_OFS_RESULT_HIGH);
        chk(q, 32'h71);
        rd(`ADCC_OFS_RESULT_LOW);
        chk(q, 32'h80);
        rd(`ADCC_OFS_RESULT_HIGH);
        $display("test conversions done");
    endtask

    // Low byte read freezes results until the high byte is read
    task automatic t_lock;
        apb(1'b1, `ADCC_OFS_MUX_SELECT, 32'h03);
        convert(10'h155, 32'h93);
        rd(`ADCC_OFS_RESULT_LOW);
        chk(q, 32'h55);
        convert(10'h2aa, 32'h93);
        chk(q & 32'h10, 32'h10);
        rd(`ADCC_OFS_RESULT_HIGH);
        chk(q, 32'h1);
        rd(`ADCC_OFS_RESULT_LOW);
        chk(q, 32'h55);
        rd(`ADCC_OFS_RESULT_HIGH);
        convert(10'h2aa, 32'h93);
        rd(`ADCC_OFS_RESULT_LOW);
        chk(q, 32'haa);
        rd(`ADCC_OFS_RESULT_HIGH);
        chk(q, 32'h2);
        $display("test lock done");
    endtask

    // Request raised, then cleared by service and by write-one
    task automatic t_irq;
        wca(32'hdb);
        apb(1'b1, `ADCC_OFS_MUX_SELECT, 32'h05);
        chk({26'h0, channel_select_out}, 32'h03);
        wait_idle();
        chk({26'h0, channel_select_out}, 32'h05);
        convert(10'h011, 32'h9b);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        rd(`ADCC_OFS_CONTROL_A);
        chk((q & 32'h10) | {31'h0, irq}, 32'h0);
        convert(10'h022, 32'h9b);
        chk({31'h0, irq}, 32'h1);
        wca(32'h9b);
        rd(`ADCC_OFS_CONTROL_A);
        chk((q & 32'h10) | {31'h0, irq}, 32'h0);
        $display("test interrupt done");
    endtask

    // Edge starts once; held level and mid-run edge start nothing
    task automatic t_trig;
        apb(1'b1, `ADCC_OFS_CONTROL_B, 32'h02);
        wca(32'hb3);
        @(posedge pclk);
        trigger_sources <= 8'h04;
        repeat (24) @(posedge pclk);
        rd(`ADCC_OFS_CONTROL_A);
        chk(q & 32'h40, 32'h40);
        trigger_sources <= 8'h00;
        @(posedge pclk);
        trigger_sources <= 8'h04;
        wait_idle();
        wca(32'hb3);
        repeat (300) @(posedge pclk);
        rd(`ADCC_OFS_CONTROL_A);
        chk(q & 32'h50, 32'h0);
        trigger_sources <= 8'h00;
        $display("test trigger done");
    endtask

    // Self trigger keeps converting with the flag cleared
    task automatic t_free;
        apb(1'b1, `ADCC_OFS_CONTROL_B, 32'h00);
        wca(32'hf3);
        repeat (150) @(posedge pclk);
        wca(32'hb3);
        repeat (120) @(posedge pclk);
        rd(`ADCC_OFS_CONTROL_A);
        chk(q & 32'h50, 32'h50);
        wca(32'h83);
        wait_idle();
        wca(32'h00);
        $display("test free running done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        trigger_sources = 8'h00;
        irq_ack = 1'b0;
        level = 10'h000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_conv();
        t_lock();
        t_irq();
        t_trig();
        t_free();
        tally_and_finish();
    end
endmodule // adcc_conversion_control_bench
`default_nettype wire
